// ==== rtl/irp_sequencer.sv ====
// How it works
// - Carrier period is the carrier setting times 250 ns, settings 8 to 255.
// - DC carrier bit makes pulses a steady active level, no modulation.
// - Carrier duty is 50, 37, 25 or 12 percent from a two-bit field.
// - Pause between complete patterns is setting times 10 us.
// - Eight-bit setting gives the pause between repeated sub-pattern bursts.
// - Two-bit output select routes waveform to LED or GPIO.
// - Inversion flips waveform on both LED and GPIO outputs.
// - Five-bit drive field sets integrated LED current.
// - Burst-complete flag set after everything finishes, seen in both status registers.
// - Interrupt enable also drives the interrupt pin on completion.
// - Host writes zero to the clear bit; flag and pin drop.
// - Force bit raises interrupt flags and pin regardless of burst.
// - Busy stays high for the whole pattern, clears back in idle.
// - Complete pattern reruns count extra times; 0xFF runs forever.
// - Sub-pattern reruns count extra times; 0xFF runs forever.
// - Start bit begins sequencing at the first pattern location.
// - Run-once part first, then sub-pattern loops, then complete patterns with pauses.
// - Engine works only while enabled and then owns the LED driver pin.
// - Byte 0xFF ends the pattern; 0xFE loads next byte as jump address.
// - Upper nibble indexes pulse time, lower nibble gap time, in carrier periods.
// - Zero timeword keeps previous LED state into next pulse or gap.
`timescale 1ns/1ps
`default_nettype none
module irp_sequencer #(
    parameter int PAUSE_CYC = irp_pkg::PAUSE_UNIT_CYC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    output logic [7:0] REG_RDATA_O,
    // Emitter side
    output logic LED_O,
    output logic GPIO_O,
    output logic [4:0] LED_DRIVE_O,
    output logic LED_DRIVER_PIN_OWNED_O,
    output logic INT_O
);
    logic [7:0] pat_mem_ff [256];
    logic [15:0] tw_mem_ff [16];
    logic [7:0] enable_ff, bank_ff, drive_ff, icfg_ff, ocfg_ff;
    logic [7:0] isnl_ff, isoff_ff, ipnl_ff, ipoff_ff, ibt_ff;
    logic start_ff, flag_ff, int_ff, led_ff, gpio_ff, mod_ff;
    logic [7:0] rdata_ff;
    irp_pkg::irp_state_t state_ff;
    logic [7:0] ptr_ff, rep_addr_ff, sub_left_ff, pat_left_ff, pause_ff, cur_ff;
    logic rep_seen_ff;
    logic [15:0] dur_ff;
    logic [6:0] car_pre_ff;
    logic [7:0] car_step_ff;
    logic [11:0] pause_pre_ff;

    // Register decode
    wire logic ram_hit = REG_ADDR_I <= irp_pkg::ADDR_RAM_LAST;
    wire logic tw_sel = bank_ff[irp_pkg::BIT_TW_SELECT];
    wire logic [7:0] pat_addr = {bank_ff[irp_pkg::BIT_RAM_BANK], REG_ADDR_I[6:0]};
    wire logic tw_hit = ram_hit && tw_sel && (REG_ADDR_I <= irp_pkg::ADDR_TW_LAST);
    wire logic pat_hit = ram_hit && !tw_sel;
    wire logic [3:0] tw_addr = REG_ADDR_I[4:1];
    wire logic pat_wr = REG_WE_I && pat_hit;
    wire logic tw_wr_hi = REG_WE_I && tw_hit && !REG_ADDR_I[0];
    wire logic tw_wr_lo = REG_WE_I && tw_hit && REG_ADDR_I[0];
    // A start written while busy or disabled stays pending
    wire logic wr_start = REG_WE_I && (REG_ADDR_I == irp_pkg::ADDR_BURST_START)
        && REG_WDATA_I[irp_pkg::BIT_START];
    wire logic wr_clear = REG_WE_I && (REG_ADDR_I == irp_pkg::ADDR_INTERRUPT_CLEAR)
        && !REG_WDATA_I[irp_pkg::BIT_INT_CLEAR];
    wire logic engine_en = enable_ff[irp_pkg::BIT_ENGINE_EN];
    wire logic busy = state_ff != irp_pkg::ST_IDLE;
    wire logic force_int = icfg_ff[irp_pkg::BIT_INT_FORCE];
    wire logic flag_view = flag_ff || force_int;
    irp_pkg::irp_outcfg_t ocfg;
    assign ocfg = irp_pkg::irp_outcfg_t'(ocfg_ff[5:0]);

    // Carrier timing; settings below 8 are held at 8
    wire logic [7:0] ibt_eff = (ibt_ff < irp_pkg::CARRIER_MIN) ? irp_pkg::CARRIER_MIN : ibt_ff;
    wire logic car_pre_end = car_pre_ff == 7'(irp_pkg::CARRIER_UNIT_CYC - 1);
    wire logic car_wrap = car_pre_end && (car_step_ff == ibt_eff - 8'h01);
    wire logic [9:0] ibt3 = {2'h0, ibt_eff} + {1'h0, ibt_eff, 1'h0};
    wire logic [7:0] duty_thr = (ocfg.duty == irp_pkg::DUTY_50) ? {1'h0, ibt_eff[7:1]} :
        (ocfg.duty == irp_pkg::DUTY_37) ? {1'h0, ibt3[9:3]} :
        (ocfg.duty == irp_pkg::DUTY_25) ? {2'h0, ibt_eff[7:2]} : {3'h0, ibt_eff[7:3]};
    wire logic carrier_on = car_step_ff < duty_thr;
    wire logic seg_restart = (state_ff == irp_pkg::ST_FETCH)
        || (state_ff == irp_pkg::ST_PULSE && dur_ff == 16'h0000);
    // No carrier in turnover cycles, so a pulse ends on whole periods
    wire logic seg_hold = (state_ff == irp_pkg::ST_FETCH) || (dur_ff == 16'h0000);
    wire logic wave = mod_ff && (ocfg.dc_mode || (carrier_on && !seg_hold));
    wire logic wave_pol = wave ^ ocfg.invert;
    // Unselected output rests at the idle level set by the invert bit
    wire logic nxt_led = (ocfg.out_sel == irp_pkg::OUT_LED) ? wave_pol : ocfg.invert;
    wire logic nxt_gpio = (ocfg.out_sel == irp_pkg::OUT_GPIO) ? wave_pol : ocfg.invert;

    // Pattern fetch
    wire logic [7:0] fetch_byte = pat_mem_ff[ptr_ff];
    wire logic [7:0] jump_byte = pat_mem_ff[ptr_ff + 8'h01];
    wire logic [15:0] tw_pulse = tw_mem_ff[fetch_byte[7:4]];
    wire logic [15:0] tw_gap = tw_mem_ff[cur_ff[3:0]];
    wire logic sub_more = rep_seen_ff && (isnl_ff == irp_pkg::LOOP_FOREVER || sub_left_ff != 8'h00);
    wire logic pat_more = (ipnl_ff == irp_pkg::LOOP_FOREVER) || (pat_left_ff != 8'h00);
    wire logic pause_step = pause_pre_ff == 12'(PAUSE_CYC - 1);
    wire logic accept = start_ff && engine_en && !busy;
    wire logic done = (state_ff == irp_pkg::ST_FETCH) && (fetch_byte == irp_pkg::OP_END)
        && !sub_more && !pat_more;

    // Pattern and timeword storage
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < 256; i++) begin
                pat_mem_ff[i] <= irp_pkg::RST_BYTE;
            end
            for (int j = 0; j < 16; j++) begin
                tw_mem_ff[j] <= 16'h0000;
            end
        end else if (pat_wr) begin
            pat_mem_ff[pat_addr] <= REG_WDATA_I;
        end else if (tw_wr_hi) begin
            tw_mem_ff[tw_addr][15:8] <= REG_WDATA_I;
        end else if (tw_wr_lo) begin
            tw_mem_ff[tw_addr][7:0] <= REG_WDATA_I;
        end
    end

    // Control registers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            enable_ff <= irp_pkg::RST_BYTE;
            bank_ff <= irp_pkg::RST_BYTE;
            drive_ff <= irp_pkg::RST_BYTE;
            icfg_ff <= irp_pkg::RST_BYTE;
            ocfg_ff <= irp_pkg::RST_BYTE;
            isnl_ff <= irp_pkg::RST_BYTE;
            isoff_ff <= irp_pkg::RST_BYTE;
            ipnl_ff <= irp_pkg::RST_BYTE;
            ipoff_ff <= irp_pkg::RST_BYTE;
            ibt_ff <= irp_pkg::RST_CARRIER;
        end else if (REG_WE_I) begin
            case (REG_ADDR_I)
                irp_pkg::ADDR_MAIN_ENABLE: enable_ff <= REG_WDATA_I;
                irp_pkg::ADDR_MEMORY_BANK_CONFIG: bank_ff <= REG_WDATA_I;
                irp_pkg::ADDR_LED_DRIVE_CONFIG: drive_ff <= REG_WDATA_I;
                irp_pkg::ADDR_BEAM_INTERRUPT_CONFIG: icfg_ff <= REG_WDATA_I;
                irp_pkg::ADDR_BEAM_OUTPUT_CONFIG: ocfg_ff <= REG_WDATA_I;
                irp_pkg::ADDR_SUBPATTERN_LOOP_COUNT: isnl_ff <= REG_WDATA_I;
                irp_pkg::ADDR_SUBPATTERN_PAUSE: isoff_ff <= REG_WDATA_I;
                irp_pkg::ADDR_PATTERN_LOOP_COUNT: ipnl_ff <= REG_WDATA_I;
                irp_pkg::ADDR_PATTERN_PAUSE: ipoff_ff <= REG_WDATA_I;
                irp_pkg::ADDR_CARRIER_PERIOD: ibt_ff <= REG_WDATA_I;
                default: ;
            endcase
        end
    end

    // Start bit and burst flag; a new request and completion beat a clear
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            start_ff <= 1'b0;
            flag_ff <= 1'b0;
        end else begin
            if (wr_start) begin
                start_ff <= 1'b1;
            end else if (accept) begin
                start_ff <= 1'b0;
            end
            if (done) begin
                flag_ff <= 1'b1;
            end else if (wr_clear) begin
                flag_ff <= 1'b0;
            end
        end
    end

    // Carrier and pause prescalers, restarted at each segment
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            car_pre_ff <= 7'h00;
            car_step_ff <= 8'h00;
            pause_pre_ff <= 12'h000;
        end else if (seg_restart) begin
            car_pre_ff <= 7'h00;
            car_step_ff <= 8'h00;
            pause_pre_ff <= 12'h000;
        end else begin
            car_pre_ff <= car_pre_end ? 7'h00 : car_pre_ff + 7'h01;
            if (car_wrap) begin
                car_step_ff <= 8'h00;
            end else if (car_pre_end) begin
                car_step_ff <= car_step_ff + 8'h01;
            end
            pause_pre_ff <= pause_step ? 12'h000 : pause_pre_ff + 12'h001;
        end
    end

    // Sequencer
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff <= irp_pkg::ST_IDLE;
            ptr_ff <= 8'h00;
            rep_addr_ff <= 8'h00;
            rep_seen_ff <= 1'b0;
            sub_left_ff <= 8'h00;
            pat_left_ff <= 8'h00;
            pause_ff <= 8'h00;
            cur_ff <= 8'h00;
            dur_ff <= 16'h0000;
            mod_ff <= 1'b0;
        end else if (!engine_en) begin
            state_ff <= irp_pkg::ST_IDLE;
            mod_ff <= 1'b0;
        end else begin
            case (state_ff)
                irp_pkg::ST_IDLE: begin
                    mod_ff <= 1'b0;
                    if (accept) begin
                        state_ff <= irp_pkg::ST_FETCH;
                        ptr_ff <= 8'h00;
                        rep_seen_ff <= 1'b0;
                        sub_left_ff <= isnl_ff;
                        pat_left_ff <= ipnl_ff;
                    end
                end
                irp_pkg::ST_FETCH: begin
                    if (fetch_byte == irp_pkg::OP_END) begin
                        mod_ff <= 1'b0;
                        if (sub_more) begin
                            if (isnl_ff != irp_pkg::LOOP_FOREVER) begin
                                sub_left_ff <= sub_left_ff - 8'h01;
                            end
                            ptr_ff <= rep_addr_ff;
                            pause_ff <= isoff_ff;
                            state_ff <= irp_pkg::ST_SUBPAUSE;
                        end else if (pat_more) begin
                            if (ipnl_ff != irp_pkg::LOOP_FOREVER) begin
                                pat_left_ff <= pat_left_ff - 8'h01;
                            end
                            ptr_ff <= 8'h00;
                            rep_seen_ff <= 1'b0;
                            sub_left_ff <= isnl_ff;
                            pause_ff <= ipoff_ff;
                            state_ff <= irp_pkg::ST_PATPAUSE;
                        end else begin
                            state_ff <= irp_pkg::ST_IDLE;
                        end
                    end else if (fetch_byte == irp_pkg::OP_JUMP) begin
                        rep_addr_ff <= jump_byte;
                        rep_seen_ff <= 1'b1;
                        ptr_ff <= ptr_ff + 8'h02;
                    end else begin
                        cur_ff <= fetch_byte;
                        dur_ff <= tw_pulse;
                        if (tw_pulse != 16'h0000) begin
                            mod_ff <= 1'b1;
                        end
                        state_ff <= irp_pkg::ST_PULSE;
                    end
                end
                irp_pkg::ST_PULSE: begin
                    if (dur_ff == 16'h0000) begin
                        dur_ff <= tw_gap;
                        if (tw_gap != 16'h0000) begin
                            mod_ff <= 1'b0;
                        end
                        state_ff <= irp_pkg::ST_GAP;
                    end else if (car_wrap) begin
                        dur_ff <= dur_ff - 16'h0001;
                    end
                end
                irp_pkg::ST_GAP: begin
                    if (dur_ff == 16'h0000) begin
                        ptr_ff <= ptr_ff + 8'h01;
                        state_ff <= irp_pkg::ST_FETCH;
                    end else if (car_wrap) begin
                        dur_ff <= dur_ff - 16'h0001;
                    end
                end
                irp_pkg::ST_SUBPAUSE, irp_pkg::ST_PATPAUSE: begin
                    if (pause_ff == 8'h00) begin
                        state_ff <= irp_pkg::ST_FETCH;
                    end else if (pause_step) begin
                        pause_ff <= pause_ff - 8'h01;
                    end
                end
                default: state_ff <= irp_pkg::ST_IDLE;
            endcase
        end
    end

    // Read mux, one cycle behind the address
    wire logic [7:0] rd_ram = tw_hit ? (REG_ADDR_I[0] ? tw_mem_ff[tw_addr][7:0] : tw_mem_ff[tw_addr][15:8]) :
        pat_hit ? pat_mem_ff[pat_addr] : 8'h00;
    logic [7:0] rd_reg;
    always_comb begin
        rd_reg = 8'h00;
        case (REG_ADDR_I)
            irp_pkg::ADDR_MAIN_ENABLE: rd_reg = enable_ff;
            irp_pkg::ADDR_MEMORY_BANK_CONFIG: rd_reg = bank_ff;
            irp_pkg::ADDR_LED_DRIVE_CONFIG: rd_reg = drive_ff;
            irp_pkg::ADDR_DEVICE_STATUS: rd_reg[irp_pkg::BIT_STATUS_INT] = flag_view;
            irp_pkg::ADDR_BEAM_INTERRUPT_CONFIG: rd_reg = icfg_ff;
            irp_pkg::ADDR_BEAM_OUTPUT_CONFIG: rd_reg = ocfg_ff;
            irp_pkg::ADDR_SUBPATTERN_LOOP_COUNT: rd_reg = isnl_ff;
            irp_pkg::ADDR_SUBPATTERN_PAUSE: rd_reg = isoff_ff;
            irp_pkg::ADDR_PATTERN_LOOP_COUNT: rd_reg = ipnl_ff;
            irp_pkg::ADDR_PATTERN_PAUSE: rd_reg = ipoff_ff;
            irp_pkg::ADDR_CARRIER_PERIOD: rd_reg = ibt_ff;
            irp_pkg::ADDR_BEAM_STATUS: begin
                rd_reg[irp_pkg::BIT_BEAM_INT] = flag_view;
                rd_reg[irp_pkg::BIT_BEAM_BUSY] = busy;
            end
            irp_pkg::ADDR_BURST_START: rd_reg[irp_pkg::BIT_START] = start_ff;
            default: rd_reg = rd_ram;
        endcase
    end

    // Output flops
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_ff <= 8'h00;
            int_ff <= 1'b0;
            led_ff <= 1'b0;
            gpio_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_reg;
            int_ff <= (flag_ff && icfg_ff[irp_pkg::BIT_INT_EN]) || force_int;
            led_ff <= nxt_led;
            gpio_ff <= nxt_gpio;
        end
    end

    assign REG_RDATA_O = rdata_ff;
    assign LED_O = led_ff;
    assign GPIO_O = gpio_ff;
    assign LED_DRIVE_O = drive_ff[irp_pkg::LED_DRIVE_W-1:0];
    assign LED_DRIVER_PIN_OWNED_O = enable_ff[irp_pkg::BIT_ENGINE_EN];
    assign INT_O = int_ff;
endmodule
`default_nettype wire

// ==== shared/irp_pkg.sv ====
package irp_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_MAIN_ENABLE = 8'h80;
    localparam logic [7:0] ADDR_MEMORY_BANK_CONFIG = 8'h8D;
    localparam logic [7:0] ADDR_LED_DRIVE_CONFIG = 8'h8F;
    localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h93;
    localparam logic [7:0] ADDR_BEAM_INTERRUPT_CONFIG = 8'hA0;
    localparam logic [7:0] ADDR_BEAM_OUTPUT_CONFIG = 8'hA1;
    localparam logic [7:0] ADDR_SUBPATTERN_LOOP_COUNT = 8'hA2;
    localparam logic [7:0] ADDR_SUBPATTERN_PAUSE = 8'hA3;
    localparam logic [7:0] ADDR_PATTERN_LOOP_COUNT = 8'hA4;
    localparam logic [7:0] ADDR_PATTERN_PAUSE = 8'hA5;
    localparam logic [7:0] ADDR_CARRIER_PERIOD = 8'hA6;
    localparam logic [7:0] ADDR_BEAM_STATUS = 8'hA8;
    localparam logic [7:0] ADDR_BURST_START = 8'hA9;
    localparam logic [7:0] ADDR_INTERRUPT_CLEAR = 8'hDE;
    // Memory window below the control registers
    localparam logic [7:0] ADDR_RAM_LAST = 8'h7F;
    localparam logic [7:0] ADDR_TW_LAST = 8'h1F;
    // Field positions
    localparam int BIT_PON = 0;
    localparam int BIT_ENGINE_EN = 7;
    localparam int BIT_RAM_BANK = 0;
    localparam int BIT_TW_SELECT = 1;
    localparam int BIT_STATUS_INT = 3;
    localparam int BIT_INT_EN = 5;
    localparam int BIT_INT_FORCE = 6;
    localparam int BIT_BEAM_INT = 1;
    localparam int BIT_BEAM_BUSY = 0;
    localparam int BIT_START = 1;
    localparam int BIT_INT_CLEAR = 3;
    localparam int LED_DRIVE_W = 5;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_CARRIER = 8'h69;
    // Pattern operators and special counts
    localparam logic [7:0] OP_END = 8'hFF;
    localparam logic [7:0] OP_JUMP = 8'hFE;
    localparam logic [7:0] LOOP_FOREVER = 8'hFF;
    localparam logic [7:0] CARRIER_MIN = 8'h08;
    // Output select codes
    localparam logic [1:0] OUT_LED = 2'h0;
    localparam logic [1:0] OUT_GPIO = 2'h1;
    // Duty codes
    localparam logic [1:0] DUTY_50 = 2'h0;
    localparam logic [1:0] DUTY_37 = 2'h1;
    localparam logic [1:0] DUTY_25 = 2'h2;
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CARRIER_UNIT_NS = 250;
    localparam int PAUSE_UNIT_US = 10;
    localparam int CARRIER_UNIT_CYC = (CARRIER_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PAUSE_UNIT_CYC = (PAUSE_UNIT_US * 1000000) / CLK_PERIOD_PS;

    typedef struct packed {
        logic invert;
        logic [1:0] out_sel;
        logic dc_mode;
        logic [1:0] duty;
    } irp_outcfg_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_PULSE,
        ST_GAP,
        ST_SUBPAUSE,
        ST_PATPAUSE
    } irp_state_t;
endpackage

// ==== verif/irp_sequencer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module irp_sequencer_checker #(
    parameter int PAUSE_CYC = irp_pkg::PAUSE_UNIT_CYC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic [7:0] REG_RDATA_O,
    // Emitter side
    input wire logic LED_O,
    input wire logic GPIO_O,
    input wire logic [4:0] LED_DRIVE_O,
    input wire logic LED_DRIVER_PIN_OWNED_O,
    input wire logic INT_O
);
    logic [7:0] int_cfg_ff;
    logic [7:0] out_cfg_ff;
    wire logic wr_drive = REG_WE_I && REG_ADDR_I == irp_pkg::ADDR_LED_DRIVE_CONFIG;
    wire logic wr_enable = REG_WE_I && REG_ADDR_I == irp_pkg::ADDR_MAIN_ENABLE;
    wire logic wr_int = REG_WE_I && REG_ADDR_I == irp_pkg::ADDR_BEAM_INTERRUPT_CONFIG;
    wire logic wr_out = REG_WE_I && REG_ADDR_I == irp_pkg::ADDR_BEAM_OUTPUT_CONFIG;
    wire logic wr_clear = REG_WE_I && REG_ADDR_I == irp_pkg::ADDR_INTERRUPT_CLEAR;
    // Shadow copies, since the checker cannot see the register file
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            int_cfg_ff <= 8'h00;
            out_cfg_ff <= 8'h00;
        end else begin
            int_cfg_ff <= wr_int ? REG_WDATA_I : int_cfg_ff;
            out_cfg_ff <= wr_out ? REG_WDATA_I : out_cfg_ff;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    drive_follow_a: assert property (
        wr_drive |-> ##2 LED_DRIVE_O == $past(REG_WDATA_I[4:0], 2)) else $error("drive missed write");
    owned_follow_a: assert property (
        wr_enable |-> ##2 LED_DRIVER_PIN_OWNED_O == $past(REG_WDATA_I[7], 2)) else $error("ownership missed enable");
    force_int_a: assert property (
        wr_int && REG_WDATA_I[6] |-> ##[1:3] INT_O) else $error("force left pin low");
    int_gate_a: assert property (
        $rose(INT_O) |-> int_cfg_ff[5] || int_cfg_ff[6]) else $error("pin rose while disabled");
    int_clear_a: assert property (
        wr_clear && !REG_WDATA_I[3] && !int_cfg_ff[6] |-> ##3 !INT_O) else $error("clear left pin high");
    idle_level_a: assert property (
        (!LED_DRIVER_PIN_OWNED_O && !REG_WE_I) [*3] |-> LED_O == out_cfg_ff[5] && GPIO_O == out_cfg_ff[5])
        else $error("idle level wrong");
    route_led_a: assert property (
        (out_cfg_ff[4:3] == irp_pkg::OUT_LED && !REG_WE_I) [*3] |-> GPIO_O == out_cfg_ff[5])
        else $error("gpio active while led chosen");
    route_gpio_a: assert property (
        (out_cfg_ff[4:3] == irp_pkg::OUT_GPIO && !REG_WE_I) [*3] |-> LED_O == out_cfg_ff[5])
        else $error("led active while gpio chosen");
endmodule
bind irp_sequencer irp_sequencer_checker #(.PAUSE_CYC(PAUSE_CYC)) i_chk (.CLK_I(CLK_I), .RST_I(RST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WE_I(REG_WE_I), .REG_RDATA_O(REG_RDATA_O),
    .LED_O(LED_O), .GPIO_O(GPIO_O), .LED_DRIVE_O(LED_DRIVE_O), .LED_DRIVER_PIN_OWNED_O(LED_DRIVER_PIN_OWNED_O),
    .INT_O(INT_O));
`default_nettype wire

// ==== verif/irp_emitter_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module irp_emitter_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Emitter drive
    input wire logic wave_i,
    // Observations
    output logic [15:0] rise_cnt_o,
    output logic [15:0] period_o,
    output logic [15:0] width_o
);
    logic [15:0] since_rise_ff;
    logic wave_ff;
    // Emitter lights on the high level only, so rises count flashes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {rise_cnt_o, period_o, width_o, since_rise_ff, wave_ff} <= '0;
        end else begin
            wave_ff <= wave_i;
            since_rise_ff <= (wave_i && !wave_ff) ? 16'h0001 : since_rise_ff + 16'h0001;
            if (wave_i && !wave_ff) begin
                rise_cnt_o <= rise_cnt_o + 16'h0001;
                period_o <= since_rise_ff;
            end
            if (!wave_i && wave_ff) begin
                width_o <= since_rise_ff;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/irp_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module irp_sequencer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic we = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, rd_val;
    logic led, gpio, owned, irq;
    logic [4:0] drive;
    logic [15:0] led_rise, led_per, led_wid, gpio_rise, base_led, base_gpio;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    localparam logic [7:0] TW [4] = '{8'h00, 8'h02, 8'h00, 8'h01};
    // Second pulse byte is also the repeated part
    localparam logic [7:0] PAT [5] = '{8'h01, 8'hFE, 8'h03, 8'h01, 8'hFF};
    localparam logic [7:0] OUT_CFG [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h00, 8'h00};
    localparam int LED_RISES [8] = '{4, 4, 4, 4, 2, 0, 8, 6};
    localparam int CAR_CYC = 8 * irp_pkg::CARRIER_UNIT_CYC;
    // Tests need roughly half of this
    localparam int CYCLE_LIMIT = 90000;

    always #2 clk = ~clk;

    irp_sequencer #(.PAUSE_CYC(4)) i_dut (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WE_I(we), .REG_RDATA_O(rdata), .LED_O(led), .GPIO_O(gpio), .LED_DRIVE_O(drive),
        .LED_DRIVER_PIN_OWNED_O(owned), .INT_O(irq));
    irp_emitter_model i_led (.clk_i(clk), .rst_i(rst), .wave_i(led), .rise_cnt_o(led_rise), .period_o(led_per),
        .width_o(led_wid));
    irp_emitter_model i_gpio (.clk_i(clk), .rst_i(rst), .wave_i(gpio), .rise_cnt_o(gpio_rise), .period_o(),
        .width_o());

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    // Read data is registered one edge behind the address
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 rd_val = rdata;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        rd(8'hA8);
        while (rd_val[0] !== 1'b0 && n < 20000) begin
            rd(8'hA8);
            n++;
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            bad_count++;
            $display("[FAIL] cycle limit expected idle seen running");
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'hA6);
        check("carrier reset", rd_val, 8'h69);
        wr(8'h93, 8'hFF);
        wr(8'hB0, 8'h55);
        rd(8'h93);
        check("status read only", rd_val, 8'h00);
        rd(8'hB0);
        check("unmapped", rd_val, 8'h00);
        wr(8'h8F, 8'h15);
        wr(8'h80, 8'h81);
        rd(8'h80);
        check("drive", drive, 5'h15);
        check("pin owned", owned, 1'b1);
        wr(8'h8D, 8'h02);
        for (int k = 0; k < 4; k++) wr(8'(k), TW[k]);
        wr(8'h8D, 8'h00);
        for (int k = 0; k < 5; k++) wr(8'(k), PAT[k]);
        wr(8'hA6, 8'h08);
        wr(8'hA3, 8'h01);
        wr(8'hA5, 8'h01);
        wr(8'hA0, 8'h40);
        rd(8'h93);
        check("forced flag", rd_val[3], 1'b1);
        check("forced pin", irq, 1'b1);
        wr(8'hA0, 8'h00);
        wr(8'hDE, 8'h00);
        rd(8'hA8);
        check("flag cleared", rd_val[1], 1'b0);
        check("pin cleared", irq, 1'b0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            base_led = led_rise;
            base_gpio = gpio_rise;
            wr(8'hA0, (i == 0) ? 8'h00 : 8'h20);
            wr(8'hA1, OUT_CFG[i]);
            wr(8'hA2, (i == 7) ? 8'h01 : 8'h00);
            wr(8'hA4, (i == 6) ? 8'h01 : 8'h00);
            wr(8'hA9, 8'h02);
            rd(8'hA8);
            check("busy", rd_val[0], 1'b1);
            rd(8'hA9);
            check("start", rd_val, 8'h00);
            wait_idle();
            check("led rises", led_rise - base_led, 16'(LED_RISES[i]));
            check("gpio rises", gpio_rise - base_gpio, (i == 5) ? 16'h0004 : 16'h0000);
            if (i < 4 || i > 5) check("period", led_per, 16'(CAR_CYC));
            if (i < 4) check("width", led_wid, 16'((4 - i) * irp_pkg::CARRIER_UNIT_CYC));
            rd(8'hA8);
            check("engine flag", rd_val[1], 1'b1);
            check("idle", rd_val[0], 1'b0);
            check("int pin", irq, i != 0);
            rd(8'h93);
            check("status flag", rd_val[3], 1'b1);
            wr(8'hDE, 8'h00);
            rd(8'hA8);
            check("flag cleared", rd_val[1], 1'b0);
            $display("test run %0d done", i);
        end
        wr(8'hA4, 8'hFF);
        wr(8'hA9, 8'h02);
        // Nearly two passes long, so a pattern count of zero would have ended
        repeat (8000) @(posedge clk);
        rd(8'hA8);
        check("still busy", rd_val[0], 1'b1);
        wr(8'h80, 8'h01);
        rd(8'hA8);
        check("aborted", rd_val[0], 1'b0);
        check("pin released", owned, 1'b0);
        wr(8'hA1, 8'h20);
        repeat (4) @(posedge clk);
        #1;
        check("inverted led", led, 1'b1);
        check("inverted gpio", gpio, 1'b1);
        $display("test continuous done");
        wrap_up();
    end
endmodule
`default_nettype wire
